//--- src/iah_bus_timer.sv
// Bus timer: ends a stalled acknowledge cycle with a bus error.
// Assumes the strobe flag comes from this board's own registered data strobes.
`timescale 1ns/1ps
`default_nettype none
module iah_bus_timer (
	input wire logic ref_clk,
	input wire logic rst_b,
	iah_timer_if.timer tif
);
	typedef struct packed {
		logic [11:0] cnt;
		logic berr;
	} iah_tmr_s;

	iah_tmr_s cur_ff;
	iah_tmr_s nxt_cur;

	always_comb begin
		nxt_cur = cur_ff;
		if (!tif.strobe_lo) begin
			nxt_cur.cnt = 12'h000;
			nxt_cur.berr = 1'b0;
		end else if (cur_ff.cnt != iah_pkg::TIMEOUT_CYC) begin
			nxt_cur.cnt = cur_ff.cnt + 12'h001;
		end else begin
			// Fires once T has passed, well inside 2T, and holds until strobes rise
			nxt_cur.berr = 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			cur_ff <= '0;
		end else begin
			cur_ff <= nxt_cur;
		end
	end

	assign tif.berr_drive = cur_ff.berr;

	timeout_fire_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(tif.strobe_lo && cur_ff.cnt == iah_pkg::TIMEOUT_CYC) |=> tif.berr_drive)
		else $error("bus timer missed its time-out");

	timeout_early_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		$rose(tif.berr_drive) |-> $past(cur_ff.cnt) == iah_pkg::TIMEOUT_CYC)
		else $error("bus timer fired before its time-out");
endmodule // iah_bus_timer
`default_nettype wire

//--- src/iah_handler.sv
// Interrupt handler master for backplane interrupt acknowledge cycles.
// Assumes bus pins are resolved outside; dtack, berr and AS inputs are resynchronised here.
`timescale 1ns/1ps
`default_nettype none
module iah_handler (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic start,
	input wire logic [2:0] irq_level,
	input wire logic [1:0] sid_width,
	output logic busy,
	output logic done,
	output logic berr_seen,
	output logic [31:0] status_id,
	output logic dev_wants,
	input wire logic dev_granted,
	input wire logic as_b_i,
	output logic as_b_o,
	output logic as_b_oe,
	output logic ds0_b_o,
	output logic ds0_b_oe,
	output logic ds1_b_o,
	output logic ds1_b_oe,
	output logic iack_b_o,
	output logic iack_b_oe,
	output logic [2:0] addr_o,
	output logic addr_oe,
	output logic lword_b_o,
	output logic lword_b_oe,
	output logic write_b_o,
	output logic write_b_oe,
	input wire logic dtack_b_i,
	input wire logic berr_b_i,
	output logic berr_b_o,
	output logic berr_b_oe,
	input wire logic [31:0] data_i
);
	iah_pkg::iah_state_s cur_ff;
	iah_pkg::iah_state_s nxt_cur;
	iah_timer_if tif ();

	iah_bus_timer u_timer (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.tif(tif)
	);

	// Keeps only the lanes that the requested width transfers
	function automatic logic [31:0] lane_mask(input logic [1:0] w, input logic [31:0] d);
		logic [31:0] m;
		m = 32'h0000_00FF;
		if (w == iah_pkg::WIDTH_DOUBLE) begin
			m = 32'h0000_FFFF;
		end else if (w == iah_pkg::WIDTH_QUAD) begin
			m = 32'hFFFF_FFFF;
		end
		return d & m;
	endfunction

	always_comb begin
		nxt_cur = cur_ff;
		nxt_cur.done = 1'b0;
		nxt_cur.cnt = cur_ff.cnt + 8'h01;
		// Two-stage synchronisers on every incoming strobe
		nxt_cur.dtack_m = dtack_b_i;
		nxt_cur.dtack_s = cur_ff.dtack_m;
		nxt_cur.berr_m = berr_b_i;
		nxt_cur.berr_s = cur_ff.berr_m;
		nxt_cur.as_m = as_b_i;
		nxt_cur.as_s = cur_ff.as_m;
		unique case (cur_ff.st)
			iah_pkg::ST_IDLE: begin
				if (start) begin
					nxt_cur.addr = irq_level;
					nxt_cur.width = sid_width;
					nxt_cur.dev_wants = 1'b1;
					nxt_cur.st = iah_pkg::ST_REQ;
				end
			end
			iah_pkg::ST_REQ: begin
				if (dev_granted && cur_ff.as_s) begin
					nxt_cur.iack_oe = 1'b1;
					nxt_cur.addr_oe = 1'b1;
					nxt_cur.write_oe = 1'b1;
					nxt_cur.lword_o = (cur_ff.width != iah_pkg::WIDTH_QUAD);
					nxt_cur.ds0_o = 1'b1;
					nxt_cur.ds1_o = 1'b1;
					nxt_cur.ds_oe = 1'b1;
					nxt_cur.as_o = 1'b1;
					nxt_cur.as_oe = 1'b1;
					nxt_cur.cnt = 8'h00;
					nxt_cur.st = iah_pkg::ST_ADDR;
				end
			end
			iah_pkg::ST_ADDR: begin
				// Address and IACK set up before AS falls, rounded up
				if (cur_ff.cnt >= iah_pkg::AS_SETUP_CYC - 8'h01) begin
					nxt_cur.as_o = 1'b0;
					nxt_cur.cnt = 8'h00;
					nxt_cur.st = iah_pkg::ST_ASLO;
				end
			end
			iah_pkg::ST_ASLO: begin
				if (cur_ff.cnt >= iah_pkg::DS_HIGH_CYC - 8'h01 && cur_ff.dtack_s
					&& cur_ff.berr_s) begin
					nxt_cur.ds0_o = 1'b0;
					// DSB falls with DSA, so wider reads are never taken as one byte
					nxt_cur.ds1_o = (cur_ff.width == iah_pkg::WIDTH_BYTE);
					nxt_cur.st = iah_pkg::ST_WACK;
				end
			end
			iah_pkg::ST_WACK: begin
				// All bus outputs but the timer's BERR hold here until an answer arrives
				if (!cur_ff.dtack_s) begin
					nxt_cur.berr_seen = 1'b0;
					nxt_cur.cnt = 8'h00;
					nxt_cur.st = iah_pkg::ST_SETTLE;
				end else if (!cur_ff.berr_s) begin
					nxt_cur.berr_seen = 1'b1;
					nxt_cur.ds0_o = 1'b1;
					nxt_cur.ds1_o = 1'b1;
					nxt_cur.cnt = 8'h00;
					nxt_cur.st = iah_pkg::ST_DSREL;
				end
			end
			iah_pkg::ST_SETTLE: begin
				if (cur_ff.cnt >= iah_pkg::DATA_SETTLE_CYC - 8'h01) begin
					nxt_cur.sid = lane_mask(cur_ff.width, data_i);
					nxt_cur.ds0_o = 1'b1;
					nxt_cur.ds1_o = 1'b1;
					nxt_cur.cnt = 8'h00;
					nxt_cur.st = iah_pkg::ST_DSREL;
				end
			end
			iah_pkg::ST_DSREL: begin
				// WRITE stays driven high past the strobes' rise
				if (cur_ff.cnt >= iah_pkg::WRITE_HOLD_CYC - 8'h01) begin
					nxt_cur.iack_oe = 1'b0;
					nxt_cur.addr_oe = 1'b0;
					nxt_cur.write_oe = 1'b0;
					nxt_cur.ds_oe = 1'b0;
					nxt_cur.st = iah_pkg::ST_LREL;
				end
			end
			iah_pkg::ST_LREL: begin
				// Lines already released, AS rises next
				nxt_cur.as_o = 1'b1;
				nxt_cur.cnt = 8'h00;
				nxt_cur.st = iah_pkg::ST_ASUP;
			end
			iah_pkg::ST_ASUP: begin
				if (cur_ff.cnt >= iah_pkg::AS_RELEASE_CYC - 8'h01) begin
					nxt_cur.as_oe = 1'b0;
					nxt_cur.dev_wants = 1'b0;
					nxt_cur.done = 1'b1;
					nxt_cur.st = iah_pkg::ST_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			cur_ff <= '{st: iah_pkg::ST_IDLE, cnt: 8'h00, width: 2'h0, addr: 3'h0,
				as_o: 1'b1, as_oe: 1'b0, ds0_o: 1'b1, ds1_o: 1'b1, ds_oe: 1'b0,
				iack_oe: 1'b0, addr_oe: 1'b0, write_oe: 1'b0, lword_o: 1'b1,
				dev_wants: 1'b0, done: 1'b0, berr_seen: 1'b0, sid: 32'h0000_0000,
				dtack_m: 1'b1, dtack_s: 1'b1, berr_m: 1'b1, berr_s: 1'b1,
				as_m: 1'b1, as_s: 1'b1};
		end else begin
			cur_ff <= nxt_cur;
		end
	end

	assign tif.strobe_lo = cur_ff.ds_oe && !(cur_ff.ds0_o && cur_ff.ds1_o);

	assign busy = (cur_ff.st != iah_pkg::ST_IDLE);
	assign done = cur_ff.done;
	assign berr_seen = cur_ff.berr_seen;
	assign status_id = cur_ff.sid;
	assign dev_wants = cur_ff.dev_wants;
	assign as_b_o = cur_ff.as_o;
	assign as_b_oe = cur_ff.as_oe;
	assign ds0_b_o = cur_ff.ds0_o;
	assign ds0_b_oe = cur_ff.ds_oe;
	assign ds1_b_o = cur_ff.ds1_o;
	assign ds1_b_oe = cur_ff.ds_oe;
	assign iack_b_o = 1'b0;
	assign iack_b_oe = cur_ff.iack_oe;
	assign addr_o = cur_ff.addr;
	assign addr_oe = cur_ff.addr_oe;
	assign lword_b_o = cur_ff.lword_o;
	assign lword_b_oe = cur_ff.addr_oe;
	assign write_b_o = cur_ff.write_oe;
	assign write_b_oe = cur_ff.write_oe;
	assign berr_b_o = 1'b0;
	assign berr_b_oe = tif.berr_drive;

	sequence strobes_rise_s;
		cur_ff.ds_oe && !cur_ff.ds0_o ##1 cur_ff.ds0_o && cur_ff.ds1_o;
	endsequence

	sequence lines_free_s;
		!cur_ff.iack_oe && !cur_ff.addr_oe && !cur_ff.write_oe && !cur_ff.ds_oe;
	endsequence

	write_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		strobes_rise_s |-> cur_ff.write_oe)
		else $error("WRITE released together with the strobes");

	release_order_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(cur_ff.as_oe && $rose(cur_ff.as_o)) |-> lines_free_s)
		else $error("AS rose while bus lines were still driven");

	want_drop_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		$fell(cur_ff.dev_wants) |-> lines_free_s)
		else $error("bus request dropped while lines were still driven");

	as_release_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(cur_ff.as_oe && $rose(cur_ff.as_o)) |-> ##[1:2] !cur_ff.as_oe)
		else $error("AS kept driven too long after rising");

	ds_after_ack_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		$fell(cur_ff.ds0_o) |-> $past(cur_ff.dtack_s) && $past(cur_ff.berr_s))
		else $error("data strobe fell while DTACK or BERR still low");

	hold_until_ack_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(cur_ff.st == iah_pkg::ST_WACK && cur_ff.dtack_s && cur_ff.berr_s) |=>
		$stable(cur_ff.addr) && $stable(cur_ff.as_o) && $stable(cur_ff.ds0_o)
		&& $stable(cur_ff.ds1_o) && cur_ff.iack_oe)
		else $error("bus lines changed before an answer");

	settle_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		$rose(cur_ff.st == iah_pkg::ST_SETTLE) |-> (!cur_ff.ds0_o)[*3])
		else $error("DSA released before data settled");

	sync_depth_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		cur_ff.dtack_s == $past(dtack_b_i, 2))
		else $error("DTACK synchroniser depth wrong");
endmodule // iah_handler
`default_nettype wire

//--- src/iah_pkg.sv
// Constants and types for the interrupt acknowledge handler.
// Assumes a single 100 MHz clock; all bus timing is counted in its cycles.
package iah_pkg;
	localparam int CLK_PERIOD_NS = 10;

	// Least times round up, longest times round down, never below one cycle
	function automatic int cyc_min(input int ns);
		int c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction

	function automatic int cyc_max(input int ns);
		int c;
		c = ns / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction

	localparam int AS_SETUP_NS = 35;
	localparam int DS_HIGH_NS = 40;
	localparam int DATA_SETTLE_NS = 25;
	localparam int WRITE_HOLD_NS = 10;
	localparam int AS_RELEASE_NS = 25;
	localparam int BUS_TIMEOUT_NS = 16000;

	localparam logic [7:0] AS_SETUP_CYC = 8'(cyc_min(AS_SETUP_NS));
	localparam logic [7:0] DS_HIGH_CYC = 8'(cyc_min(DS_HIGH_NS));
	localparam logic [7:0] DATA_SETTLE_CYC = 8'(cyc_min(DATA_SETTLE_NS));
	localparam logic [7:0] WRITE_HOLD_CYC = 8'(cyc_min(WRITE_HOLD_NS));
	localparam logic [7:0] AS_RELEASE_CYC = 8'(cyc_max(AS_RELEASE_NS));
	localparam logic [11:0] TIMEOUT_CYC = 12'(cyc_min(BUS_TIMEOUT_NS));

	// Status/Id width requested by the user
	localparam logic [1:0] WIDTH_BYTE = 2'h0;
	localparam logic [1:0] WIDTH_DOUBLE = 2'h1;
	localparam logic [1:0] WIDTH_QUAD = 2'h2;

	typedef enum logic [8:0] {
		ST_IDLE = 9'h001,
		ST_REQ = 9'h002,
		ST_ADDR = 9'h004,
		ST_ASLO = 9'h008,
		ST_WACK = 9'h010,
		ST_SETTLE = 9'h020,
		ST_DSREL = 9'h040,
		ST_LREL = 9'h080,
		ST_ASUP = 9'h100
	} iah_st_e;

	typedef struct packed {
		iah_st_e st;
		logic [7:0] cnt;
		logic [1:0] width;
		logic [2:0] addr;
		logic as_o;
		logic as_oe;
		logic ds0_o;
		logic ds1_o;
		logic ds_oe;
		logic iack_oe;
		logic addr_oe;
		logic write_oe;
		logic lword_o;
		logic dev_wants;
		logic done;
		logic berr_seen;
		logic [31:0] sid;
		logic dtack_m;
		logic dtack_s;
		logic berr_m;
		logic berr_s;
		logic as_m;
		logic as_s;
	} iah_state_s;
endpackage : iah_pkg

//--- src/iah_timer_if.sv
// Link between the handler and its bus timer.
// Assumes both ends share ref_clk.
`timescale 1ns/1ps
`default_nettype none
interface iah_timer_if;
	logic strobe_lo;
	logic berr_drive;
	modport master (output strobe_lo, input berr_drive);
	modport timer (input strobe_lo, output berr_drive);
endinterface : iah_timer_if
`default_nettype wire

//--- verif/iah_intr_model.sv
// Behavioural responding interrupter on the far side of the acknowledge bus.
// Assumes resolved bus levels sampled on the bench clock; released lines float high.
`timescale 1ns/1ps
`default_nettype none
module iah_intr_model (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic ds0_b,
	input wire logic ds1_b,
	input wire logic iackin_b,
	input wire logic as_b,
	input wire logic lword_b,
	input wire logic [1:0] mode,
	input wire logic [7:0] dly,
	input wire logic [31:0] sid,
	output logic dtack_b,
	output logic berr_b,
	output logic [31:0] data
);
	logic [7:0] cnt;
	logic drv;
	logic ds0_q;
	logic chain_b;
	logic pass_b;
	logic [2:0] chain_cnt;
	localparam logic [2:0] CHAIN_DLY = 3'h4;

	// Slot-one chain driver, then one non-participating interrupter that passes the acknowledge on
	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			ds0_q <= 1'b1;
			chain_b <= 1'b1;
			pass_b <= 1'b1;
			chain_cnt <= 3'h0;
		end else begin
			ds0_q <= ds0_b;
			if (as_b) begin
				// Chain outputs go high on the first edge after AS rises
				chain_b <= 1'b1;
				pass_b <= 1'b1;
				chain_cnt <= 3'h0;
			end else begin
				if (ds0_q && !ds0_b && !iackin_b) begin
					chain_cnt <= 3'h1;
				end else if (chain_cnt != 3'h0 && chain_cnt != CHAIN_DLY) begin
					chain_cnt <= chain_cnt + 3'h1;
				end
				if (chain_cnt == CHAIN_DLY) begin
					chain_b <= 1'b0;
				end
				// Never drives data, so it passes on once its own input is seen low
				pass_b <= chain_b;
			end
		end
	end

	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			dtack_b <= 1'b1;
			berr_b <= 1'b1;
			data <= 32'hFFFF_FFFF;
			drv <= 1'b0;
			cnt <= 8'h00;
		end else if (ds0_b && ds1_b) begin
			// Data lines let go one cycle before the answer line
			cnt <= 8'h00;
			data <= 32'hFFFF_FFFF;
			drv <= 1'b0;
			if (!drv) begin
				dtack_b <= 1'b1;
				berr_b <= 1'b1;
			end
		end else if (!ds0_b && !pass_b && dtack_b && berr_b) begin
			cnt <= cnt + 8'h01;
			if (cnt == 8'h01 && mode == 2'h0) begin
				drv <= 1'b1;
				// Late second strobe means a single byte answer
				data <= ds1_b ? {24'hFF_FFFF, sid[7:0]} :
					(lword_b ? {16'hFFFF, sid[15:0]} : sid);
			end
			if (cnt == dly && mode == 2'h0) begin
				dtack_b <= 1'b0;
			end
			if (cnt == dly && mode == 2'h1) begin
				berr_b <= 1'b0;
			end
		end
	end
endmodule // iah_intr_model
`default_nettype wire

//--- verif/interrupt_ack_cycle_logic_test.sv
// Self-checking bench for the interrupt acknowledge handler.
// Assumes the behavioural interrupter model; undriven bus lines float high.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
	$display("ERROR %s expected %h seen %h", nm, e, g); end end
module interrupt_ack_cycle_logic_test;
	logic ref_clk, rst_b, start, dev_granted, busy, done, berr_seen, dev_wants;
	logic as_b_o, as_b_oe, ds0_b_o, ds0_b_oe, ds1_b_o, ds1_b_oe, iack_b_o, iack_b_oe;
	logic addr_oe, lword_b_o, lword_b_oe, write_b_o, write_b_oe, berr_b_o, berr_b_oe;
	logic m_dtack, m_berr;
	logic [2:0] irq_level, addr_o;
	logic [1:0] sid_width, mode;
	logic [7:0] dly;
	logic [31:0] sid, status_id, data_w, last_sid;
	int n_fail, total_checks, cyc;
	wire as_w = as_b_oe ? as_b_o : 1'b1;
	wire ds0_w = ds0_b_oe ? ds0_b_o : 1'b1;
	wire ds1_w = ds1_b_oe ? ds1_b_o : 1'b1;
	wire iack_w = iack_b_oe ? iack_b_o : 1'b1;
	wire lword_w = lword_b_oe ? lword_b_o : 1'b1;
	wire write_w = write_b_oe ? write_b_o : 1'b1;
	wire berr_w = m_berr & (berr_b_oe ? berr_b_o : 1'b1);

	iah_handler u_iah_handler (.ref_clk(ref_clk), .rst_b(rst_b), .start(start),
		.irq_level(irq_level), .sid_width(sid_width), .busy(busy), .done(done),
		.berr_seen(berr_seen), .status_id(status_id), .dev_wants(dev_wants),
		.dev_granted(dev_granted), .as_b_i(as_w), .as_b_o(as_b_o), .as_b_oe(as_b_oe),
		.ds0_b_o(ds0_b_o), .ds0_b_oe(ds0_b_oe), .ds1_b_o(ds1_b_o), .ds1_b_oe(ds1_b_oe),
		.iack_b_o(iack_b_o), .iack_b_oe(iack_b_oe), .addr_o(addr_o), .addr_oe(addr_oe),
		.lword_b_o(lword_b_o), .lword_b_oe(lword_b_oe), .write_b_o(write_b_o),
		.write_b_oe(write_b_oe), .dtack_b_i(m_dtack), .berr_b_i(berr_w),
		.berr_b_o(berr_b_o), .berr_b_oe(berr_b_oe), .data_i(data_w));

	iah_intr_model u_iah_intr_model (.ref_clk(ref_clk), .rst_b(rst_b), .ds0_b(ds0_w),
		.ds1_b(ds1_w), .iackin_b(iack_w), .as_b(as_w), .lword_b(lword_w), .mode(mode), .dly(dly),
		.sid(sid), .dtack_b(m_dtack), .berr_b(m_berr), .data(data_w));

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	// Bus grant follows the request one cycle later
	always @(posedge ref_clk) begin
		dev_granted <= #1 dev_wants;
		cyc++;
		if (cyc == 10000) begin
			n_fail++;
			complete_run();
		end
	end

	task automatic complete_run();
		$display("Checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic run(input logic [2:0] lvl, input logic [1:0] w, input logic [1:0] md,
		input logic [7:0] d, input logic [31:0] s, input logic [31:0] exp_sid);
		int n;
		int tb;
		@(posedge ref_clk);
		#1;
		irq_level = lvl;
		sid_width = w;
		mode = md;
		dly = d;
		sid = s;
		start = 1'b1;
		@(posedge ref_clk);
		#1;
		start = 1'b0;
		n = 0;
		while (ds0_w !== 1'b0 && n < 200) begin
			@(posedge ref_clk);
			#1;
			n++;
		end
		`CHK("prev answer high", 1'b1, m_dtack & berr_w)
		`CHK("data idle at strobe", 32'hFFFF_FFFF, data_w)
		`CHK("as low", 1'b0, as_w)
		`CHK("iack low", 1'b0, iack_w)
		`CHK("code", lvl, addr_o)
		`CHK("write high", 1'b1, write_w)
		`CHK("second strobe", (w == iah_pkg::WIDTH_BYTE), ds1_w)
		`CHK("lword", (w != iah_pkg::WIDTH_QUAD), lword_w)
		`CHK("busy", 1'b1, busy)
		n = 0;
		tb = 0;
		while (done !== 1'b1 && n < 4000) begin
			@(posedge ref_clk);
			#1;
			n++;
			if (tb == 0 && berr_b_oe === 1'b1) begin
				tb = n;
			end
			if (ds0_w === 1'b0 && m_dtack === 1'b1 && berr_w === 1'b1) begin
				`CHK("code held", lvl, addr_o)
			end
		end
		`CHK("done", 1'b1, done)
		`CHK("status id", exp_sid, status_id)
		`CHK("bus error flag", (md != 2'h0), berr_seen)
		`CHK("lines released", 9'h000, {as_b_oe, iack_b_oe, addr_oe, ds0_b_oe, ds1_b_oe,
			lword_b_oe, write_b_oe, dev_wants, busy})
		if (md == 2'h2) begin
			`CHK("timer window", 1'b1, tb >= iah_pkg::TIMEOUT_CYC && tb <= 2 * iah_pkg::TIMEOUT_CYC)
		end
		last_sid = status_id;
	endtask

	task automatic t_codes_widths();
		logic [31:0] s;
		logic [1:0] w;
		for (int l = 1; l < 8; l++) begin
			s = 32'hC3A5_5A00 | 32'(l);
			w = 2'(l % 3);
			run(3'(l), w, 2'h0, 8'h02, s, w == iah_pkg::WIDTH_BYTE ? {24'h0, s[7:0]} :
				(w == iah_pkg::WIDTH_DOUBLE ? {16'h0, s[15:0]} : s));
		end
	endtask

	task automatic t_slow_answer();
		run(3'h5, iah_pkg::WIDTH_QUAD, 2'h0, 8'h28, 32'h1234_5678, 32'h1234_5678);
	endtask

	task automatic t_error_end();
		run(3'h2, iah_pkg::WIDTH_DOUBLE, 2'h1, 8'h03, 32'hDEAD_BEEF, last_sid);
	endtask

	task automatic t_timer();
		run(3'h6, iah_pkg::WIDTH_BYTE, 2'h2, 8'h03, 32'h0000_0099, last_sid);
	endtask

	initial begin
		rst_b = 1'b0;
		start = 1'b0;
		irq_level = 3'h0;
		sid_width = 2'h0;
		mode = 2'h0;
		dly = 8'h02;
		sid = 32'h0;
		repeat (4) @(posedge ref_clk);
		#1;
		rst_b = 1'b1;
		t_codes_widths();
		t_slow_answer();
		t_error_end();
		t_timer();
		t_codes_widths();
		complete_run();
	end
endmodule // interrupt_ack_cycle_logic_test
`default_nettype wire
